/* wake_map.svh */
`ifndef WAKE_MAP_SVH
`define WAKE_MAP_SVH

// register byte offsets
`define WAKE_HOLD_ARM_OFS 12'h004
`define WAKE_HOLD_CLEAR_OFS 12'h008
`define WAKE_GATE_OFS 12'h00C
`define WAKE_STATUS_OFS 12'h010
`define WAKE_POLARITY_OFS 12'h014
`define WAKE_RISE_OFS 12'h018
`define WAKE_FALL_OFS 12'h01C
`define WAKE_FORCE_OFS 12'h020
`define WAKE_IRQ_MASK_OFS 12'h024
`define WAKE_CTRL_OFS 12'h028

// reset values
`define WAKE_GATE_RST 7'h0F
`define WAKE_POLARITY_RST 7'h00
`define WAKE_HOLD_ARM_RST 7'h30
`define WAKE_FORCE_RST 7'h00
`define WAKE_MASK_RST 14'h0000

// field positions
`define WAKE_CTRL_RAIL_BIT 0
`define WAKE_CTRL_TRANS_BIT 1
`define WAKE_MASK_FALL_LSB 7

`endif

/* wake_pkg.sv */
package wake_pkg;

  // per-input conditioning view
  typedef struct packed {
    logic [6:0] asserted;
    logic [6:0] active;
  } cond_type;

  // software control bits
  typedef struct packed {
    logic rail_off;
    logic transition;
  } ctrl_type;

endpackage

/* wake_input_conditioning.sv */
`timescale 1ns/100ps
`include "wake_map.svh"
// Function
// - each set gate bit passes its wake input to the power request, gate resets to Fh.
// - a clear gate bit keeps its input from the power request whatever its level, unless the standby rail is off and its buffer force bit is set.
// - in a battery transition an input with gate and buffer force clear does not assert its hold latch.
// - polarity bit 1 inverts the pin making it active high, 0 (default) keeps it active low.
// - a rising edge on a wake pin with its input buffer enabled sets its rising edge flag, reset 0.
// - a falling edge on a wake pin with its input buffer enabled sets its falling edge flag, reset 0.
// - the hold latch acts on the polarity adjusted signal.
// - an asserted input beats a hold clear request.
// - with the standby rail powered only the gate bits enable the input buffers.
module wake_input_conditioning #(
  parameter int N = 7
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [N-1:0] wake_input_pins,
  output logic power_request_output,
  output logic irq
);

  logic [N-1:0] gate_q;
  logic [N-1:0] pol_q;
  logic [N-1:0] arm_q;
  logic [N-1:0] force_q;
  logic [N-1:0] rise_q;
  logic [N-1:0] fall_q;
  logic [N-1:0] hold_q;
  logic [N-1:0] pin_q;
  logic [2*N-1:0] mask_q;
  wake_pkg::ctrl_type ctrl_q;
  wake_pkg::cond_type cond;
  logic [N-1:0] buf_en;
  logic [N-1:0] pass;
  logic [N-1:0] rise_ev;
  logic [N-1:0] fall_ev;
  logic [N-1:0] hold_clr;
  logic wr;
  logic rd;
  logic [31:0] rd_d;
  logic req_d;

  // bus strobes, one access cycle
  assign wr = psel & penable & pwrite & ~pready;
  assign rd = psel & penable & ~pwrite & ~pready;
  assign hold_clr = (wr && paddr == `WAKE_HOLD_CLEAR_OFS) ?
    pwdata[N-1:0] : '0;

  // buffer enable and conditioning per input
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_in
      assign buf_en[i] = gate_q[i] | (ctrl_q.rail_off & force_q[i]);
      assign cond.asserted[i] = ~(wake_input_pins[i] ^ pol_q[i]);
      // no latch in transition unless enabled
      assign cond.active[i] = cond.asserted[i] & buf_en[i];
      assign pass[i] = arm_q[i] ? hold_q[i] : cond.active[i];
      assign rise_ev[i] = buf_en[i] & ~pin_q[i] & wake_input_pins[i];
      assign fall_ev[i] = buf_en[i] & pin_q[i] & ~wake_input_pins[i];
    end
  endgenerate

  // configuration registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gate_q <= N'(`WAKE_GATE_RST);
      pol_q <= N'(`WAKE_POLARITY_RST);
      arm_q <= N'(`WAKE_HOLD_ARM_RST);
      force_q <= N'(`WAKE_FORCE_RST);
      mask_q <= (2*N)'(`WAKE_MASK_RST);
      ctrl_q <= '0;
    end else if (wr) begin
      unique case (paddr)
        `WAKE_GATE_OFS: gate_q <= pwdata[N-1:0];
        `WAKE_POLARITY_OFS: pol_q <= pwdata[N-1:0];
        `WAKE_HOLD_ARM_OFS: arm_q <= pwdata[N-1:0];
        `WAKE_FORCE_OFS: force_q <= pwdata[N-1:0];
        `WAKE_IRQ_MASK_OFS: mask_q <= pwdata[2*N-1:0];
        `WAKE_CTRL_OFS: begin
          ctrl_q.rail_off <= pwdata[`WAKE_CTRL_RAIL_BIT];
          ctrl_q.transition <= pwdata[`WAKE_CTRL_TRANS_BIT];
        end
        default: ;
      endcase
    end
  end

  // pin history for edge detection
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_q <= '1;
    end else begin
      pin_q <= wake_input_pins;
    end
  end

  // sticky edge flags, set beats clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      if (wr && paddr == `WAKE_RISE_OFS) begin
        rise_q <= (rise_q & ~pwdata[N-1:0]) | rise_ev;
      end else begin
        rise_q <= rise_q | rise_ev;
      end
      if (wr && paddr == `WAKE_FALL_OFS) begin
        fall_q <= (fall_q & ~pwdata[N-1:0]) | fall_ev;
      end else begin
        fall_q <= fall_q | fall_ev;
      end
    end
  end

  // hold latches
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_q <= '0;
    end else begin
      hold_q <= (hold_q & ~hold_clr) | (cond.active & arm_q);
    end
  end

  // power request and interrupt outputs
  assign req_d = |pass;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      power_request_output <= 1'b0;
      irq <= 1'b0;
    end else begin
      power_request_output <= req_d;
      irq <= |({fall_q, rise_q} & mask_q);
    end
  end

  // read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (paddr)
      `WAKE_HOLD_ARM_OFS: rd_d[N-1:0] = arm_q;
      `WAKE_GATE_OFS: rd_d[N-1:0] = gate_q;
      `WAKE_STATUS_OFS: rd_d = {16'h0000, 1'b0, hold_q, 1'b0,
                                cond.asserted};
      `WAKE_POLARITY_OFS: rd_d[N-1:0] = pol_q;
      `WAKE_RISE_OFS: rd_d[N-1:0] = rise_q;
      `WAKE_FALL_OFS: rd_d[N-1:0] = fall_q;
      `WAKE_FORCE_OFS: rd_d[N-1:0] = force_q;
      `WAKE_IRQ_MASK_OFS: rd_d[2*N-1:0] = mask_q;
      `WAKE_CTRL_OFS: rd_d[1:0] = {ctrl_q.transition, ctrl_q.rail_off};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // apb answer, one wait state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (rd) begin
        prdata <= rd_d;
      end
    end
  end

  rise_sets_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rise_ev[0] |=> rise_q[0])
    else $error("rising edge lost");
  fall_sets_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    fall_ev[0] |=> fall_q[0])
    else $error("falling edge lost");
  flag_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rise_q[1] && !(wr && paddr == `WAKE_RISE_OFS) |=> rise_q[1])
    else $error("rising flag dropped");
  gate_blocks_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (gate_q == '0 && !ctrl_q.rail_off && (hold_q & arm_q) == '0)
    |=> !power_request_output)
    else $error("gated input reached request");
  gate_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    gate_q[0] && !arm_q[0] && !wake_input_pins[0] && !pol_q[0]
    |=> power_request_output)
    else $error("open input did not request");
  hold_prio_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    arm_q[2] && cond.active[2] |=> hold_q[2])
    else $error("hold cleared while asserted");
  force_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ctrl_q.rail_off && !gate_q[3] |-> !cond.active[3])
    else $error("force acted with rail on");
  pol_inv_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pol_q[0] |-> cond.asserted[0] == wake_input_pins[0])
    else $error("polarity not applied");
  trans_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctrl_q.transition && !gate_q[5] && !force_q[5] && !hold_q[5]
    |=> !hold_q[5])
    else $error("latch set while disabled");

  // ready lasts one cycle
  ready_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pready
    |=> !pready)
    else $error("ready held too long");

  // ready follows first access cycle
  ready_follow_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    psel && penable && !pready
    |=> pready)
    else $error("ready missing");

  // no bus errors
  no_error_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    1'b1
    |-> !pslverr)
    else $error("error response seen");

  gate_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr && paddr == `WAKE_GATE_OFS
    |=> gate_q[0] == $past(pwdata[0]))
    else $error("gate write lost");

  pol_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr && paddr == `WAKE_POLARITY_OFS
    |=> pol_q[0] == $past(pwdata[0]))
    else $error("polarity write lost");

  rise_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr && paddr == `WAKE_RISE_OFS && pwdata[0] && !rise_ev[0]
    |=> !rise_q[0])
    else $error("rising flag not cleared");

  fall_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr && paddr == `WAKE_FALL_OFS && pwdata[0] && !fall_ev[0]
    |=> !fall_q[0])
    else $error("falling flag not cleared");

  fall_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    fall_q[1] && !(wr && paddr == `WAKE_FALL_OFS)
    |=> fall_q[1])
    else $error("falling flag dropped");

  rise_quiet_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rise_ev[0] && !rise_q[0]
    |=> !rise_q[0])
    else $error("rising flag set without edge");

  req_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pass != '0
    |=> power_request_output)
    else $error("request missing");

  req_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pass == '0
    |=> !power_request_output)
    else $error("request without input");

  // interrupt follows unmasked flags
  irq_high_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ({fall_q, rise_q} & mask_q) != '0
    |=> irq)
    else $error("interrupt missing");

  // interrupt low when all masked
  irq_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ({fall_q, rise_q} & mask_q) == '0
    |=> !irq)
    else $error("interrupt without flag");

  edge_gated_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !gate_q[0] && !ctrl_q.rail_off
    |-> !rise_ev[0] && !fall_ev[0])
    else $error("edge seen through closed gate");

  rail_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ctrl_q.rail_off
    |-> buf_en == gate_q)
    else $error("buffer enable not from gate");

  pol_low_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pol_q[0]
    |-> cond.asserted[0] == !wake_input_pins[0])
    else $error("active low not applied");

  hold_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hold_q[2] && !hold_clr[2]
    |=> hold_q[2])
    else $error("hold latch dropped");

  hold_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hold_q[2] && hold_clr[2] && !(cond.active[2] && arm_q[2])
    |=> !hold_q[2])
    else $error("hold latch not cleared");

  hold_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    arm_q[2]
    |-> pass[2] == hold_q[2])
    else $error("armed input bypassed latch");

  gate_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rd && paddr == `WAKE_GATE_OFS
    |=> prdata[N-1:0] == $past(gate_q))
    else $error("gate read wrong");

endmodule

/* wake_source.sv */
`timescale 1ns/100ps
module wake_source (
  input wire logic sys_clk,
  input wire logic [6:0] level_req,
  output logic [6:0] wake_input_pins
);
  // contacts settle one clock after the request, idle high
  initial wake_input_pins = 7'h7F;
  always @(posedge sys_clk) begin
    wake_input_pins <= level_req;
  end
endmodule

/* wake_input_conditioning_bench.sv */
`timescale 1ns/100ps
module wake_input_conditioning_bench;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic power_request_output, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd_q;
  logic [6:0] level_req, pins;
  logic [31:0] exp_q[$];
  int n_fail, tests_run;
  wake_source u_src (.sys_clk(sys_clk), .level_req(level_req),
    .wake_input_pins(pins));
  wake_input_conditioning u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_input_pins(pins), .power_request_output(power_request_output),
    .irq(irq));
  // free running clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_fail++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic pin_to(input logic [6:0] v);
    level_req <= v;
    repeat (4) @(posedge sys_clk);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // read data checked against the oldest note
  always @(posedge sys_clk) begin
    if (pready === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
      check(prdata, exp_q.pop_front());
  end
  // watchdog
  initial begin
    #100000;
    n_fail++;
    end_sim;
  end
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    level_req = 7'h7F;
    sys_rst = 1'b1;
    n_fail = 0;
    tests_run = 0;
    rnd_q = 32'h521D2C0E;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(12'h00C, 32'h0000000F);
    rd(12'h014, 32'h0);
    rd(12'h018, 32'h0);
    rd(12'h01C, 32'h0);
    rd(12'h0FC, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h020, 32'h08);
    apb(1'b1, 12'h028, 32'h2);
    rd(12'h020, 32'h08);
    pin_to(7'h7E);
    check(power_request_output, 1);
    rd(12'h01C, 32'h1);
    rd(12'h018, 32'h0);
    apb(1'b1, 12'h01C, 32'h0);
    rd(12'h01C, 32'h1);
    apb(1'b1, 12'h01C, 32'hFFFFFFFF);
    rd(12'h01C, 32'h0);
    pin_to(7'h7F);
    check(power_request_output, 0);
    rd(12'h018, 32'h1);
    apb(1'b1, 12'h024, 32'h1);
    repeat (2) @(posedge sys_clk);
    check(irq, 1);
    apb(1'b1, 12'h018, 32'h1);
    repeat (2) @(posedge sys_clk);
    check(irq, 0);
    apb(1'b1, 12'h00C, 32'h00);
    apb(1'b1, 12'h008, 32'h7F);
    pin_to(7'h7E);
    check(power_request_output, 0);
    rd(12'h01C, 32'h0);
    apb(1'b1, 12'h014, 32'h1);
    apb(1'b1, 12'h00C, 32'h0F);
    apb(1'b1, 12'h01C, 32'h7F);
    repeat (3) @(posedge sys_clk);
    check(power_request_output, 0);
    pin_to(7'h7F);
    check(power_request_output, 1);
    rd(12'h010, 32'h1);
    // random gate values read back as seven bits
    for (int i = 0; i < 4; i++) begin
      rnd_q = xs(rnd_q);
      apb(1'b1, 12'h00C, rnd_q);
      rd(12'h00C, rnd_q & 32'h7F);
    end
    // armed input two held against a clear
    apb(1'b1, 12'h00C, 32'h0F);
    apb(1'b1, 12'h004, 32'h04);
    pin_to(7'h7B);
    apb(1'b1, 12'h008, 32'h04);
    rd(12'h010, 32'h405);
    check(power_request_output, 1);
    pin_to(7'h7F);
    apb(1'b1, 12'h008, 32'h04);
    rd(12'h010, 32'h001);
    repeat (2) @(posedge sys_clk);
    end_sim;
  end
endmodule
